// >>> rtl/scan_pkg.sv
// Purpose: Shared constants and types of the boundary-scan test port
// Assumes: One system clock; the test clock is sampled as data
// Notes:   Chain is three cells per pin: input, output enable, output
`default_nettype none
package scan_pkg;
    localparam int IR_W      = 3;
    localparam int NPINS     = 2;
    localparam int CELL_W    = 3;
    localparam int BSR_W     = NPINS * CELL_W;
    localparam int CELL_IN   = 0;
    localparam int CELL_OE   = 1;
    localparam int CELL_OUT  = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int ONES_W    = 3;
    localparam int RESET_ONES = 5;

    localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h1;
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    localparam logic [BSR_W-1:0] BSR_RESET = 6'h00;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR,
        UPD_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;
endpackage
`default_nettype wire

// >>> rtl/stream_if.sv
// Purpose: Valid/ready word carrier between the port and its FIFO
// Assumes: Both ends on the same clock
// Notes:   src drives data and valid, snk drives ready
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> rtl/scan_fifo.sv
// Purpose: Word FIFO with a registered head word
// Assumes: Synchronous active-high reset
// Notes:   Holds DEPTH words in memory plus one in the output register
`timescale 1ns/100ps
`default_nettype none
module scan_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Streams
    stream_if.snk     push_if,
    stream_if.src     pop_if
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   cnt_reg;
    logic [W-1:0]  head_reg;
    logic          head_valid_reg;

    wire do_push = push_if.valid && push_if.ready;
    wire do_load = (cnt_reg != '0) && (!head_valid_reg || pop_if.ready);
    wire do_pop  = head_valid_reg && pop_if.ready;

    assign push_if.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign pop_if.valid  = head_valid_reg;
    assign pop_if.data   = head_reg;

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_if.data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_reg     <= '0;
            rd_ptr_reg     <= '0;
            cnt_reg        <= '0;
            head_reg       <= '0;
            head_valid_reg <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_load) begin
                head_reg   <= mem[rd_ptr_reg];
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            cnt_reg        <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_load);
            head_valid_reg <= do_load || (head_valid_reg && !do_pop);
        end
    end
endmodule // scan_fifo
`default_nettype wire

// >>> rtl/scan_port.sv
// Purpose: Test access port with bypass and boundary-scan chain
// Assumes: Test clock is far slower than clk_in and sampled as data
// Notes:   Each boundary update is queued as one word for the core, unless a newer one replaces it while still pending
//
// How it works
// - Serial input is taken on each sampled test-clock rise while shifting.
// - Serial output changes only on sampled test-clock falls.
// - Serial output is driven only in shift states, otherwise released.
// - Tap state advances only on test-clock rises, using mode-select then.
// - Cells capture pin or core values, or force update values onto pins.
// - Forced and captured values move through the serial chain, and update values also leave as queued words for the core.
// - A one-bit bypass stage is the shortest serial path.
// - Instruction picks the action and the register on the serial path.
// - No test reset pin; five mode-select highs reset the tap.
`timescale 1ns/100ps
`default_nettype none
module scan_port (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    // Test link
    input  wire logic                       tck_in,
    input  wire logic                       tms_in,
    input  wire logic                       tdi_in,
    output logic                            tdo_out,
    output logic                            tdo_oe_out,
    // Device pins
    input  wire logic [scan_pkg::NPINS-1:0] pin_in,
    output logic      [scan_pkg::NPINS-1:0] pin_out,
    output logic      [scan_pkg::NPINS-1:0] pin_oe_out,
    // Core side
    input  wire logic [scan_pkg::NPINS-1:0] core_out_in,
    input  wire logic [scan_pkg::NPINS-1:0] core_oe_in,
    output logic      [scan_pkg::NPINS-1:0] core_in_out,
    // Update word stream
    output logic      [scan_pkg::BSR_W-1:0] upd_data_out,
    output logic                            upd_valid_out,
    input  wire logic                       upd_ready_in
);
    import scan_pkg::*;

    function automatic logic [NPINS-1:0] cell_field(input logic [BSR_W-1:0] w,
                                                    input int f);
        logic [NPINS-1:0] r;
        r = '0;
        for (int i = 0; i < NPINS; i++) begin
            r[i] = w[i*CELL_W + f];
        end
        return r;
    endfunction

    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        tap_state_t n;
        n = s;
        case (s)
            TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:  n = m ? SEL_DR : TAP_IDLE;
            SEL_DR:    n = m ? SEL_IR : CAP_DR;
            CAP_DR:    n = m ? EX1_DR : SH_DR;
            SH_DR:     n = m ? EX1_DR : SH_DR;
            EX1_DR:    n = m ? UPD_DR : PAU_DR;
            PAU_DR:    n = m ? EX2_DR : PAU_DR;
            EX2_DR:    n = m ? UPD_DR : SH_DR;
            UPD_DR:    n = m ? SEL_DR : TAP_IDLE;
            SEL_IR:    n = m ? TAP_RESET : CAP_IR;
            CAP_IR:    n = m ? EX1_IR : SH_IR;
            SH_IR:     n = m ? EX1_IR : SH_IR;
            EX1_IR:    n = m ? UPD_IR : PAU_IR;
            PAU_IR:    n = m ? EX2_IR : PAU_IR;
            EX2_IR:    n = m ? UPD_IR : SH_IR;
            UPD_IR:    n = m ? SEL_DR : TAP_IDLE;
            default:   n = TAP_RESET;
        endcase
        return n;
    endfunction

    // Two-stage synchronisers; first stage feeds only the second
    logic             tck_m_reg, tck_s_reg, tck_d_reg;
    logic             tms_m_reg, tms_s_reg;
    logic             tdi_m_reg, tdi_s_reg;
    logic [NPINS-1:0] pin_m_reg, pin_s_reg;

    tap_state_t       state_reg;
    tap_state_t       state_next;
    logic [IR_W-1:0]  ir_sh_reg, ir_reg;
    logic [BSR_W-1:0] bsr_reg, upd_reg;
    logic             byp_reg;
    logic             tdo_reg, tdo_oe_reg;
    logic [NPINS-1:0] pin_out_reg, pin_oe_reg;
    logic             upd_pend_reg;
    logic             upd_pend_next;
    logic [ONES_W-1:0] ones_reg;

    stream_if #(.W(BSR_W)) push_if ();
    stream_if #(.W(BSR_W)) pop_if ();

    wire tck_rise  = tck_s_reg && !tck_d_reg;
    wire tck_fall  = !tck_s_reg && tck_d_reg;
    wire shift_ir  = (state_reg == SH_IR);
    wire shift_dr  = (state_reg == SH_DR);
    wire sel_bsr   = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLE);
    wire extest    = (ir_reg == IR_EXTEST);
    wire upd_set   = tck_rise && (state_reg == UPD_DR) && sel_bsr;
    wire upd_load  = upd_pend_reg && push_if.ready;
    wire tdo_bit   = shift_ir ? ir_sh_reg[0] : (sel_bsr ? bsr_reg[0] : byp_reg);
    wire [BSR_W-1:0] cap_word;

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_cap
            assign cap_word[g*CELL_W + CELL_IN]  = pin_s_reg[g];
            assign cap_word[g*CELL_W + CELL_OE]  = core_oe_in[g];
            assign cap_word[g*CELL_W + CELL_OUT] = core_out_in[g];
        end
    endgenerate

    assign state_next    = tck_rise ? tap_next(state_reg, tms_s_reg) : state_reg;
    // Set wins over the load that would clear it
    assign upd_pend_next = upd_set || (upd_pend_reg && !upd_load);
    assign push_if.valid = upd_pend_reg;
    assign push_if.data  = upd_reg;
    assign pop_if.ready  = upd_ready_in;
    assign upd_data_out  = pop_if.data;
    assign upd_valid_out = pop_if.valid;
    assign tdo_out       = tdo_reg;
    assign tdo_oe_out    = tdo_oe_reg;
    assign pin_out       = pin_out_reg;
    assign pin_oe_out    = pin_oe_reg;
    assign core_in_out   = pin_s_reg;

    scan_fifo #(.W(BSR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .push_if (push_if),
        .pop_if  (pop_if)
    );

    always_ff @(posedge clk_in) begin
        tck_m_reg <= tck_in;
        tck_s_reg <= tck_m_reg;
        tms_m_reg <= tms_in;
        tms_s_reg <= tms_m_reg;
        tdi_m_reg <= tdi_in;
        tdi_s_reg <= tdi_m_reg;
        pin_m_reg <= pin_in;
        pin_s_reg <= pin_m_reg;
        tck_d_reg <= tck_s_reg;
    end

    // Tap state; only the mode-select walk resets it beyond rst_in
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= TAP_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction path
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ir_sh_reg <= IR_BYPASS;
            ir_reg    <= IR_BYPASS;
        end else if (tck_rise) begin
            case (state_reg)
                TAP_RESET: ir_reg    <= IR_BYPASS;
                CAP_IR:    ir_sh_reg <= IR_CAPTURE;
                SH_IR:     ir_sh_reg <= {tdi_s_reg, ir_sh_reg[IR_W-1:1]};
                UPD_IR:    ir_reg    <= ir_sh_reg;
                default:   ir_reg    <= ir_reg;
            endcase
        end
    end

    // Data registers: capture and shift stages
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bsr_reg <= BSR_RESET;
            byp_reg <= 1'b0;
        end else if (tck_rise) begin
            if (state_reg == CAP_DR) begin
                byp_reg <= 1'b0;
                if (sel_bsr) begin
                    bsr_reg <= cap_word;
                end
            end else if (shift_dr) begin
                byp_reg <= tdi_s_reg;
                if (sel_bsr) begin
                    bsr_reg <= {tdi_s_reg, bsr_reg[BSR_W-1:1]};
                end
            end
        end
    end

    // Update loads in update-DR only; a full FIFO delays the queued copy,
    // and a newer update while still pending replaces that copy
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            upd_pend_reg <= 1'b0;
            upd_reg      <= BSR_RESET;
        end else begin
            upd_pend_reg <= upd_pend_next;
            if (upd_set) begin
                upd_reg <= bsr_reg;
            end
        end
    end

    // Serial output moves on falls, released outside shift states
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg    <= tdo_bit;
            tdo_oe_reg <= shift_ir || shift_dr;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_out_reg <= '0;
            pin_oe_reg  <= '0;
        end else begin
            pin_out_reg <= extest ? cell_field(upd_reg, CELL_OUT) : core_out_in;
            pin_oe_reg  <= extest ? cell_field(upd_reg, CELL_OE) : core_oe_in;
        end
    end

    // Helper: run of rises with mode-select high
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ones_reg <= '0;
        end else if (tck_rise) begin
            ones_reg <= !tms_s_reg ? '0 :
                        (ones_reg == ONES_W'(RESET_ONES)) ? ones_reg : ones_reg + 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_fifth_high;
        tck_rise && tms_s_reg && (ones_reg == ONES_W'(RESET_ONES - 1));
    endsequence
    sequence s_ir_shift_rise;
        tck_rise && shift_ir;
    endsequence

    chk_reset_by_tms: assert property (s_fifth_high |=> state_reg == TAP_RESET)
        else $error("tap not reset after five mode-select highs");
    chk_state_on_rise: assert property (!tck_rise |=> $stable(state_reg))
        else $error("tap state moved without a test-clock rise");
    chk_tdo_on_fall: assert property (!tck_fall |=> $stable(tdo_out))
        else $error("serial output changed without a fall");
    chk_tdo_drive_shift: assert property (tck_fall |=> tdo_oe_out == $past(shift_ir || shift_dr))
        else $error("serial output enable wrong after fall");
    chk_bypass_one_bit: assert property (tck_rise && shift_dr |=> byp_reg == $past(tdi_s_reg))
        else $error("bypass stage missed serial input");
    chk_ir_shift_in: assert property (s_ir_shift_rise |=> ir_sh_reg[IR_W-1] == $past(tdi_s_reg))
        else $error("instruction shift missed serial input");
    chk_update_hold: assert property (!(tck_rise && state_reg == UPD_DR) |=> $stable(upd_reg))
        else $error("update stage changed outside update");
    chk_capture_pins: assert property (tck_rise && state_reg == CAP_DR && sel_bsr
        |=> cell_field(bsr_reg, CELL_IN) == $past(pin_s_reg))
        else $error("capture stage missed pin values");
    chk_extest_drive: assert property (extest ##1 extest
        |-> pin_out == cell_field($past(upd_reg), CELL_OUT))
        else $error("forced pin value not driven");
    chk_bypass_path: assert property (tck_fall && shift_dr && !sel_bsr |=> tdo_out == $past(byp_reg))
        else $error("bypass not on serial path");
endmodule // scan_port
`default_nettype wire

// >>> verif/scan_ctrl.sv
// Purpose: Behavioural boundary-scan controller on the far side of the link
// Assumes: Link period of 16 system clocks; drives change just after posedge
// Notes:   Serial output is sampled just before each link rise
`timescale 1ns/100ps
`default_nettype none
module scan_ctrl (
    // Clock
    input  wire logic clk_in,
    // Test link
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in
);
    localparam int HALF = 8;
    logic oe_all;

    initial begin
        tck_out = 1'b0; // Link parked steady until the first step
        tms_out = 1'b1;
        tdi_out = 1'b1;
        oe_all  = 1'b1;
    end

    // Mode and data change on the fall, half a period before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge clk_in);
        tck_out <= 1'b0;
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (HALF) @(posedge clk_in);
        tdo = tdo_in;
        oe_all = oe_all & tdo_oe_in;
        tck_out <= 1'b1;
        repeat (HALF - 1) @(posedge clk_in);
    endtask

    task automatic walk(input logic [7:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            step(seq[i], 1'b1, d);
        end
    endtask

    // Five highs reach reset from anywhere, then one low to idle
    task automatic reset_tap();
        walk(8'h1F, 6);
    endtask

    // Idle to shift, n bits LSB first, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] dout);
        logic d;
        logic oe;
        dout = 8'h00;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        oe_all = 1'b1;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        // Exit walk releases the line; keep the record of the shift steps only
        oe = oe_all;
        walk(8'h01, 2);
        oe_all = oe;
    endtask
endmodule // scan_ctrl
`default_nettype wire

// >>> verif/scan_port_tb.sv
// Purpose: Self-checking bench of the boundary-scan test port
// Assumes: Controller model drives the link; bench drives pins and core side
// Notes:   Released serial line shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module scan_port_tb;
    import scan_pkg::*;
    localparam int LIMIT = 20000;
    logic             clk_in;
    logic             rst_in;
    logic             tck, tms, tdi, tdo_out, tdo_oe_out, tdo_line;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe_out;
    logic [NPINS-1:0] core_out_in, core_oe_in, core_in_out;
    logic [BSR_W-1:0] upd_data_out;
    logic             upd_valid_out, upd_ready_in;
    logic [7:0]       got;
    int               fails = 0;
    int               n_tests = 0;
    int               cycles = 0;

    assign tdo_line = tdo_oe_out ? tdo_out : ~tdo_out;

    scan_port i_scan_port (.clk_in(clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_out(pin_oe_out), .core_out_in(core_out_in),
        .core_oe_in(core_oe_in), .core_in_out(core_in_out), .upd_data_out(upd_data_out),
        .upd_valid_out(upd_valid_out), .upd_ready_in(upd_ready_in));
    scan_ctrl i_scan_ctrl (.clk_in(clk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo_line), .tdo_oe_in(tdo_oe_out));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-edge ready pulse so exactly one head word leaves
    task automatic pop_word(input logic [BSR_W-1:0] exp);
        int k;
        k = 0;
        @(negedge clk_in);
        while (upd_valid_out !== 1'b1 && k < 60) begin
            @(negedge clk_in);
            k++;
        end
        check("update valid", {7'h00, upd_valid_out}, 8'h01);
        check("update word", {2'h0, upd_data_out}, {2'h0, exp});
        @(posedge clk_in);
        upd_ready_in <= 1'b1;
        @(posedge clk_in);
        upd_ready_in <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask

    task automatic t_reset();
        @(negedge clk_in);
        check("tdo enable", {7'h00, tdo_oe_out}, 8'h00);
        check("pin enable", {6'h00, pin_oe_out}, 8'h00);
        check("update valid", {7'h00, upd_valid_out}, 8'h00);
        i_scan_ctrl.reset_tap();
        $display("t_reset done");
    endtask

    // Instruction capture pattern, then mode-select reset back to bypass
    task automatic t_ir_reset();
        i_scan_ctrl.scan(1'b1, IR_W, {5'h00, IR_EXTEST}, got);
        check("ir capture", got, 8'h01);
        check("ir shift enable", {7'h00, i_scan_ctrl.oe_all}, 8'h01);
        i_scan_ctrl.reset_tap();
        $display("t_ir_reset done");
    endtask

    task automatic t_bypass();
        i_scan_ctrl.scan(1'b0, 8, 8'hB5, got);
        check("bypass out", got, 8'h6A);
        check("dr shift enable", {7'h00, i_scan_ctrl.oe_all}, 8'h01);
        repeat (8) @(negedge clk_in);
        check("idle enable", {7'h00, tdo_oe_out}, 8'h00);
        check("no bypass word", {7'h00, upd_valid_out}, 8'h00);
        $display("t_bypass done");
    endtask

    task automatic t_sample();
        @(posedge clk_in);
        pin_in <= 2'h2;
        core_out_in <= 2'h1;
        core_oe_in <= 2'h3;
        i_scan_ctrl.scan(1'b1, IR_W, {5'h00, IR_SAMPLE}, got);
        i_scan_ctrl.scan(1'b0, BSR_W, 8'h2A, got);
        check("sample capture", got, 8'h1E);
        check("core pin drive", {6'h00, pin_out}, 8'h01);
        check("core pin enable", {6'h00, pin_oe_out}, 8'h03);
        check("core input", {6'h00, core_in_out}, 8'h02);
        pop_word(6'h2A);
        $display("t_sample done");
    endtask

    task automatic t_extest();
        i_scan_ctrl.scan(1'b1, IR_W, {5'h00, IR_EXTEST}, got);
        i_scan_ctrl.scan(1'b0, BSR_W, 8'h26, got);
        check("extest capture", got, 8'h1E);
        pop_word(6'h26);
        check("forced drive", {6'h00, pin_out}, 8'h03);
        check("forced enable", {6'h00, pin_oe_out}, 8'h01);
        $display("t_extest done");
    endtask

    // Ten updates with the sink stalled: nine stored, one held pending
    task automatic t_fifo();
        i_scan_ctrl.scan(1'b1, IR_W, {5'h00, IR_SAMPLE}, got);
        for (int k = 0; k < 10; k++) begin
            i_scan_ctrl.scan(1'b0, BSR_W, 8'(k * 5 + 3), got);
        end
        for (int k = 0; k < 10; k++) begin
            pop_word(6'(k * 5 + 3));
        end
        repeat (10) @(negedge clk_in);
        check("drained", {7'h00, upd_valid_out}, 8'h00);
        $display("t_fifo done");
    endtask

    initial begin
        rst_in = 1'b1;
        pin_in = 2'h0;
        core_out_in = 2'h0;
        core_oe_in = 2'h0;
        upd_ready_in = 1'b0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        t_reset();
        t_ir_reset();
        t_bypass();
        t_sample();
        t_extest();
        t_fifo();
        wrap_up();
    end
endmodule // scan_port_tb
`default_nettype wire
